// ---- verilog/dsr_drive_end.sv ----
// Drive end: status, fault code and feedback words plus the parameter table.
//
// Functional notes
// - Status word read with 03 at 8448.
// - Bit0 ready, bit1 running.
// - Bit2 commanded forward, bit3 rotating forward.
// - Bit4 accelerating, bit5 decelerating.
// - Bit6 alarm, bit7 faulted.
// - Bit8 at speed reference.
// - Bit9 network reference, bit10 network run control.
// - Bit11 parameters locked.
// - Bits12-15 digital inputs 1-4.
// - Inputs 3-4 need revision 2 or later.
// - Feedback at 8451 equals output frequency parameter.
// - Feedback in tenths of a hertz, unsigned.
// - Fault code at 8449, zero means none.
// - Low fault codes 2 through 13.
// - Codes 29, 33, 38-43 for input, shorts.
// - Codes 63 through 122 for remaining faults.
// - Parameter number equals register address.
`timescale 1ns/100ps
`include "dsr_regs.svh"
module dsr_drive_end
  import dsr_pkg::*;
#(
  parameter int PARAM_COUNT = `DSR_PARAM_COUNT
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Network link
  dsr_link_if.drive link,
  // Drive state from the control logic
  input wire logic drv_ready,
  input wire logic drv_running,
  input wire logic drv_cmd_fwd,
  input wire logic drv_rot_fwd,
  input wire logic drv_accel,
  input wire logic drv_decel,
  input wire logic drv_alarm,
  input wire logic drv_ref_net,
  input wire logic drv_cmd_net,
  input wire logic drv_params_locked,
  input wire logic [DSR_F_COUNT-1:0] drv_fault_flags,
  input wire logic drv_at_ref,
  input wire logic [15:0] output_frequency_param,
  input wire logic [7:0] firmware_revision,
  // Digital input pins
  input wire logic [3:0] din_pin,
  // Parameter table towards the drive
  output logic param_wr_pulse,
  output logic [15:0] param_wr_num,
  output logic [15:0] param_wr_data,
  output logic [15:0] accel_time_one_param
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [3:0] din_meta_reg;
  logic [3:0] din_sync_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      din_meta_reg <= 4'h0;
      din_sync_reg <= 4'h0;
    end else begin
      din_meta_reg <= din_pin;
      din_sync_reg <= din_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Fault code encoding
  // --------------------------------------------------------------------------
  function automatic dsr_word_t fault_code_of(input int idx);
    dsr_word_t code;
    code = `DSR_FLT_NONE;
    unique case (idx)
      DSR_F_AUX: code = `DSR_FLT_AUX_INPUT;
      DSR_F_PWR_LOSS: code = `DSR_FLT_POWER_LOSS;
      DSR_F_UV: code = `DSR_FLT_UNDERVOLT;
      DSR_F_OV: code = `DSR_FLT_OVERVOLT;
      DSR_F_STALL: code = `DSR_FLT_STALL;
      DSR_F_MOT_OVL: code = `DSR_FLT_MOTOR_OVL;
      DSR_F_HEATSINK: code = `DSR_FLT_HEATSINK;
      DSR_F_HW_OC: code = `DSR_FLT_HW_OC;
      DSR_F_GROUND: code = `DSR_FLT_GROUND;
      DSR_F_AIN_LOSS: code = `DSR_FLT_AIN_LOSS;
      DSR_F_RESTARTS: code = `DSR_FLT_RESTARTS;
      DSR_F_U_GND: code = `DSR_FLT_U_GND;
      DSR_F_V_GND: code = `DSR_FLT_V_GND;
      DSR_F_W_GND: code = `DSR_FLT_W_GND;
      DSR_F_UV_SHORT: code = `DSR_FLT_UV_SHORT;
      DSR_F_UW_SHORT: code = `DSR_FLT_UW_SHORT;
      DSR_F_VW_SHORT: code = `DSR_FLT_VW_SHORT;
      DSR_F_SW_OC: code = `DSR_FLT_SW_OC;
      DSR_F_DRV_OVL: code = `DSR_FLT_DRIVE_OVL;
      DSR_F_PWR_UNIT: code = `DSR_FLT_POWER_UNIT;
      DSR_F_AUTOTUNE: code = `DSR_FLT_AUTOTUNE;
      DSR_F_COMM_LOSS: code = `DSR_FLT_COMM_LOSS;
      DSR_F_CHECKSUM: code = `DSR_FLT_CHECKSUM;
      DSR_F_IO_BOARD: code = `DSR_FLT_IO_BOARD;
      default: code = `DSR_FLT_NONE;
    endcase
    return code;
  endfunction

  dsr_word_t fault_code;
  logic faulted;

  // Lowest cause index wins, so the scan runs from the top down.
  always_comb begin
    fault_code = `DSR_FLT_NONE;
    for (int i = DSR_F_COUNT - 1; i >= 0; i--) begin
      if (drv_fault_flags[i]) begin
        fault_code = fault_code_of(i);
      end
    end
  end

  assign faulted = |drv_fault_flags;

  // --------------------------------------------------------------------------
  // Logic status word
  // --------------------------------------------------------------------------
  dsr_word_t status_word;
  logic din34_avail;

  assign din34_avail = firmware_revision >= `DSR_FW_DIN34_MAJOR;

  always_comb begin
    status_word = 16'h0000;
    status_word[`DSR_ST_READY] = drv_ready;
    status_word[`DSR_ST_RUNNING] = drv_running;
    status_word[`DSR_ST_CMD_FWD] = drv_cmd_fwd;
    status_word[`DSR_ST_ROT_FWD] = drv_rot_fwd;
    status_word[`DSR_ST_ACCEL] = drv_accel;
    status_word[`DSR_ST_DECEL] = drv_decel;
    status_word[`DSR_ST_ALARM] = drv_alarm;
    status_word[`DSR_ST_FAULTED] = faulted;
    status_word[`DSR_ST_AT_REF] = drv_at_ref;
    status_word[`DSR_ST_REF_NET] = drv_ref_net;
    status_word[`DSR_ST_CMD_NET] = drv_cmd_net;
    status_word[`DSR_ST_LOCKED] = drv_params_locked;
    status_word[`DSR_ST_DIN1] = din_sync_reg[0];
    status_word[`DSR_ST_DIN1 + 1] = din_sync_reg[1];
    status_word[`DSR_ST_DIN1 + 2] = din_sync_reg[2] & din34_avail;
    status_word[`DSR_ST_DIN1 + 3] = din_sync_reg[3] & din34_avail;
  end

  // --------------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------------
  logic is_read;
  logic is_write;
  logic param_range;
  logic wr_ok;
  logic rd_ok;
  logic [7:0] param_idx;
  dsr_word_t param_table [PARAM_COUNT];
  dsr_word_t rd_word;

  assign is_read = link.req_func == `DSR_FUNC_READ;
  assign is_write = link.req_func == `DSR_FUNC_WRITE;
  // Parameter 1 is the live output frequency and cannot be written.
  assign param_range = link.req_addr > `DSR_ADDR_OUT_FREQ_PARAM
    && link.req_addr < 16'(PARAM_COUNT);
  assign param_idx = link.req_addr[7:0];
  assign wr_ok = is_write && param_range && !drv_params_locked;

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 16'h0000;
    if (link.req_addr == `DSR_ADDR_LOGIC_STATUS) begin
      rd_word = status_word;
    end else if (link.req_addr == `DSR_ADDR_FAULT_CODE) begin
      rd_word = fault_code;
    end else if (link.req_addr == `DSR_ADDR_FREQ_FEEDBACK) begin
      rd_word = output_frequency_param;
    end else if (link.req_addr == `DSR_ADDR_OUT_FREQ_PARAM) begin
      rd_word = output_frequency_param;
    end else if (param_range) begin
      rd_word = param_table[param_idx];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Parameter table
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PARAM_COUNT; i++) begin
        param_table[i] <= 16'h0000;
      end
    end else if (link.req_valid && wr_ok) begin
      param_table[param_idx] <= link.req_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      param_wr_pulse <= 1'b0;
      param_wr_num <= 16'h0000;
      param_wr_data <= 16'h0000;
      accel_time_one_param <= 16'h0000;
    end else begin
      param_wr_pulse <= link.req_valid && wr_ok;
      if (link.req_valid && wr_ok) begin
        param_wr_num <= link.req_addr;
        param_wr_data <= link.req_wdata;
        if (link.req_addr == `DSR_ADDR_ACCEL_ONE_PARAM) begin
          accel_time_one_param <= link.req_wdata;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Response
  // --------------------------------------------------------------------------
  // The answer word is captured at the request edge, so a read reports the
  // state of that instant and never disturbs it.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link.rsp_valid <= 1'b0;
      link.rsp_exc <= 1'b0;
      link.rsp_data <= 16'h0000;
    end else begin
      link.rsp_valid <= link.req_valid;
      if (link.req_valid) begin
        link.rsp_exc <= !((is_read && rd_ok) || wr_ok);
        link.rsp_data <= is_read ? rd_word : link.req_wdata;
      end
    end
  end

endmodule

// ---- verilog/dsr_regs.svh ----
// Register offsets, field positions, codes and reset values of the drive status bank.
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

// ----------------------------------------------------------------------------
// Network function codes and device register addresses
// ----------------------------------------------------------------------------
`define DSR_FUNC_READ 8'h03
`define DSR_FUNC_WRITE 8'h06
`define DSR_ADDR_LOGIC_STATUS 16'h2100
`define DSR_ADDR_FAULT_CODE 16'h2101
`define DSR_ADDR_FREQ_FEEDBACK 16'h2103
`define DSR_ADDR_OUT_FREQ_PARAM 16'h0001
`define DSR_ADDR_ACCEL_ONE_PARAM 16'h0027
`define DSR_PARAM_COUNT 256

// ----------------------------------------------------------------------------
// Logic status word bit positions
// ----------------------------------------------------------------------------
`define DSR_ST_READY 0
`define DSR_ST_RUNNING 1
`define DSR_ST_CMD_FWD 2
`define DSR_ST_ROT_FWD 3
`define DSR_ST_ACCEL 4
`define DSR_ST_DECEL 5
`define DSR_ST_ALARM 6
`define DSR_ST_FAULTED 7
`define DSR_ST_AT_REF 8
`define DSR_ST_REF_NET 9
`define DSR_ST_CMD_NET 10
`define DSR_ST_LOCKED 11
`define DSR_ST_DIN1 12
`define DSR_FW_DIN34_MAJOR 8'h02

// ----------------------------------------------------------------------------
// Fault code values, decimal as the network reports them
// ----------------------------------------------------------------------------
`define DSR_FLT_NONE 16'd0
`define DSR_FLT_AUX_INPUT 16'd2
`define DSR_FLT_POWER_LOSS 16'd3
`define DSR_FLT_UNDERVOLT 16'd4
`define DSR_FLT_OVERVOLT 16'd5
`define DSR_FLT_STALL 16'd6
`define DSR_FLT_MOTOR_OVL 16'd7
`define DSR_FLT_HEATSINK 16'd8
`define DSR_FLT_HW_OC 16'd12
`define DSR_FLT_GROUND 16'd13
`define DSR_FLT_AIN_LOSS 16'd29
`define DSR_FLT_RESTARTS 16'd33
`define DSR_FLT_U_GND 16'd38
`define DSR_FLT_V_GND 16'd39
`define DSR_FLT_W_GND 16'd40
`define DSR_FLT_UV_SHORT 16'd41
`define DSR_FLT_UW_SHORT 16'd42
`define DSR_FLT_VW_SHORT 16'd43
`define DSR_FLT_SW_OC 16'd63
`define DSR_FLT_DRIVE_OVL 16'd64
`define DSR_FLT_POWER_UNIT 16'd70
`define DSR_FLT_AUTOTUNE 16'd80
`define DSR_FLT_COMM_LOSS 16'd81
`define DSR_FLT_CHECKSUM 16'd100
`define DSR_FLT_IO_BOARD 16'd122

// ----------------------------------------------------------------------------
// Host controller command port, word offsets and fields
// ----------------------------------------------------------------------------
`define DSR_H_CTRL 4'h0
`define DSR_H_ADDR 4'h1
`define DSR_H_WDATA 4'h2
`define DSR_H_RDATA 4'h3
`define DSR_H_STAT 4'h4
`define DSR_H_IRQ_STAT 4'h5
`define DSR_H_IRQ_MASK 4'h6
`define DSR_H_CTRL_START 0
`define DSR_H_CTRL_WRITE 1
`define DSR_H_IRQ_DONE 0
`define DSR_H_IRQ_EXC 1
`define DSR_H_RESET_WORD 16'h0000

`endif

// ---- verilog/dsr_pkg.sv ----
// Types shared by both ends of the drive status bank link.
package dsr_pkg;

  typedef logic [15:0] dsr_word_t;

  typedef enum logic [1:0] {
    DSR_H_IDLE,
    DSR_H_ISSUE,
    DSR_H_WAIT
  } dsr_host_state_t;

  // Fault causes; a lower index wins when several are active.
  typedef enum logic [4:0] {
    DSR_F_AUX, DSR_F_PWR_LOSS, DSR_F_UV, DSR_F_OV, DSR_F_STALL, DSR_F_MOT_OVL,
    DSR_F_HEATSINK, DSR_F_HW_OC, DSR_F_GROUND, DSR_F_AIN_LOSS, DSR_F_RESTARTS,
    DSR_F_U_GND, DSR_F_V_GND, DSR_F_W_GND, DSR_F_UV_SHORT, DSR_F_UW_SHORT,
    DSR_F_VW_SHORT, DSR_F_SW_OC, DSR_F_DRV_OVL, DSR_F_PWR_UNIT, DSR_F_AUTOTUNE,
    DSR_F_COMM_LOSS, DSR_F_CHECKSUM, DSR_F_IO_BOARD, DSR_F_COUNT
  } dsr_fault_cause_t;

endpackage

// ---- verilog/dsr_link_if.sv ----
// Network link between the master controller and the drive status bank.
`timescale 1ns/100ps
interface dsr_link_if;
  logic req_valid;
  logic [7:0] req_func;
  logic [15:0] req_addr;
  logic [15:0] req_wdata;
  logic rsp_valid;
  logic rsp_exc;
  logic [15:0] rsp_data;

  modport master (
    output req_valid, req_func, req_addr, req_wdata,
    input rsp_valid, rsp_exc, rsp_data
  );

  modport drive (
    input req_valid, req_func, req_addr, req_wdata,
    output rsp_valid, rsp_exc, rsp_data
  );
endinterface

// ---- verilog/dsr_master_end.sv ----
// Master end: software command port that issues network reads and writes.
`timescale 1ns/100ps
`include "dsr_regs.svh"
module dsr_master_end
  import dsr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Software register port
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Interrupt
  output logic irq,
  // Network link
  dsr_link_if.master link
);

  // --------------------------------------------------------------------------
  // Command registers
  // --------------------------------------------------------------------------
  dsr_host_state_t state_reg;
  dsr_word_t addr_reg;
  dsr_word_t wdata_reg;
  dsr_word_t rdata_reg;
  logic write_reg;
  logic exc_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic start;
  logic done;

  assign start = sw_wr && sw_addr == `DSR_H_CTRL && sw_wdata[`DSR_H_CTRL_START]
    && state_reg == DSR_H_IDLE;
  assign done = state_reg == DSR_H_WAIT && link.rsp_valid;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_reg <= `DSR_H_RESET_WORD;
      wdata_reg <= `DSR_H_RESET_WORD;
      write_reg <= 1'b0;
      irq_mask_reg <= 2'h0;
    end else if (sw_wr) begin
      if (sw_addr == `DSR_H_ADDR) begin
        addr_reg <= sw_wdata;
      end
      if (sw_addr == `DSR_H_WDATA) begin
        wdata_reg <= sw_wdata;
      end
      if (start) begin
        write_reg <= sw_wdata[`DSR_H_CTRL_WRITE];
      end
      if (sw_addr == `DSR_H_IRQ_MASK) begin
        irq_mask_reg <= sw_wdata[1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Transfer sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= DSR_H_IDLE;
    end else begin
      unique case (state_reg)
        DSR_H_IDLE: begin
          if (start) begin
            state_reg <= DSR_H_ISSUE;
          end
        end
        DSR_H_ISSUE: begin
          state_reg <= DSR_H_WAIT;
        end
        DSR_H_WAIT: begin
          if (link.rsp_valid) begin
            state_reg <= DSR_H_IDLE;
          end
        end
        // The fourth code of the state type is never entered; fall back to idle.
        default: begin
          state_reg <= DSR_H_IDLE;
        end
      endcase
    end
  end

  // Reads of status, fault and feedback go out with function 03, writes
  // of parameters with 06.
  assign link.req_valid = state_reg == DSR_H_ISSUE;
  assign link.req_func = write_reg ? `DSR_FUNC_WRITE : `DSR_FUNC_READ;
  assign link.req_addr = addr_reg;
  assign link.req_wdata = wdata_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= `DSR_H_RESET_WORD;
      exc_reg <= 1'b0;
    end else if (done) begin
      rdata_reg <= link.rsp_data;
      exc_reg <= link.rsp_exc;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt status, set wins over a clearing write
  // --------------------------------------------------------------------------
  logic [1:0] irq_set;
  logic [1:0] irq_clr;

  assign irq_set = {done && link.rsp_exc, done};
  assign irq_clr = (sw_wr && sw_addr == `DSR_H_IRQ_STAT) ? sw_wdata[1:0] : 2'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_rdata <= `DSR_H_RESET_WORD;
    end else if (sw_rd) begin
      unique case (sw_addr)
        `DSR_H_CTRL: sw_rdata <= {14'h0000, write_reg, 1'b0};
        `DSR_H_ADDR: sw_rdata <= addr_reg;
        `DSR_H_WDATA: sw_rdata <= wdata_reg;
        `DSR_H_RDATA: sw_rdata <= rdata_reg;
        `DSR_H_STAT: sw_rdata <= {14'h0000, exc_reg, state_reg != DSR_H_IDLE};
        `DSR_H_IRQ_STAT: sw_rdata <= {14'h0000, irq_stat_reg};
        `DSR_H_IRQ_MASK: sw_rdata <= {14'h0000, irq_mask_reg};
        default: sw_rdata <= `DSR_H_RESET_WORD;
      endcase
    end else begin
      sw_rdata <= `DSR_H_RESET_WORD;
    end
  end

endmodule

// ---- verification/dsr_link_sva.sv ----
// Checker of the link between the master end and the drive end.
`timescale 1ns/100ps
module dsr_link_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Link signals
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_exc,
  input wire logic [15:0] rsp_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_read(a);
    req_valid && req_func == 8'h03 && req_addr == a;
  endsequence
  sequence s_write;
    req_valid && req_func == 8'h06;
  endsequence
  sequence s_ok;
    rsp_valid && !rsp_exc;
  endsequence
  sequence s_refused;
    rsp_valid && rsp_exc;
  endsequence

  property p_answer;
    req_valid |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_no_spurious;
    !req_valid |=> !rsp_valid;
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
  property p_single;
    req_valid |=> !req_valid;
  endproperty
  a_single: assert property (p_single) else $error("requests back to back");
  property p_status;
    s_read(16'h2100) |=> s_ok;
  endproperty
  a_status: assert property (p_status) else $error("status read refused");
  property p_fault;
    s_read(16'h2101) |=> s_ok;
  endproperty
  a_fault: assert property (p_fault) else $error("fault read refused");
  property p_feedback;
    s_read(16'h2103) |=> s_ok;
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback read refused");
  property p_gap;
    s_read(16'h2102) |=> s_refused;
  endproperty
  a_gap: assert property (p_gap) else $error("unmapped read accepted");
  property p_echo;
    s_write |=> rsp_exc || rsp_data == $past(req_wdata);
  endproperty
  a_echo: assert property (p_echo) else $error("write answer differs");
  property p_low_write;
    s_write ##0 (req_addr < 16'h0002) |=> s_refused;
  endproperty
  a_low_write: assert property (p_low_write) else $error("low write accepted");
  property p_hold;
    !rsp_valid |-> $stable(rsp_data) && $stable(rsp_exc);
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed unasked");
endmodule

// ---- verification/tb_top.sv ----
// Testbench joining the master end and the drive end over the link.
`timescale 1ns/100ps
`include "dsr_regs.svh"
module tb_top
  import dsr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  dsr_word_t sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  dsr_word_t sw_rdata, rd, stat, wr_num, wr_data, accel_one;
  logic irq, wr_pulse;
  logic [11:0] st = 12'h000;
  logic [DSR_F_COUNT-1:0] flt = '0;
  dsr_word_t freq = 16'h0000;
  dsr_word_t pulses = 16'h0000;
  logic [7:0] rev = 8'h02;
  logic [3:0] din = 4'h0;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  dsr_word_t fcode [24] = '{16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006, 16'h0007,
    16'h0008, 16'h000c, 16'h000d, 16'h001d, 16'h0021, 16'h0026, 16'h0027, 16'h0028,
    16'h0029, 16'h002a, 16'h002b, 16'h003f, 16'h0040, 16'h0046, 16'h0050, 16'h0051,
    16'h0064, 16'h007a};

  always #4 clk_sys = ~clk_sys;

  dsr_link_if link ();
  dsr_master_end u_dsr_master_end (.clk_sys(clk_sys), .rst(rst), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq),
    .link(link));
  dsr_drive_end #(.PARAM_COUNT(`DSR_PARAM_COUNT)) u_dsr_drive_end (.clk_sys(clk_sys),
    .rst(rst), .link(link), .drv_ready(st[0]), .drv_running(st[1]), .drv_cmd_fwd(st[2]),
    .drv_rot_fwd(st[3]), .drv_accel(st[4]), .drv_decel(st[5]), .drv_alarm(st[6]),
    .drv_ref_net(st[9]), .drv_cmd_net(st[10]), .drv_params_locked(st[11]),
    .drv_fault_flags(flt), .drv_at_ref(st[8]), .output_frequency_param(freq),
    .firmware_revision(rev), .din_pin(din), .param_wr_pulse(wr_pulse),
    .param_wr_num(wr_num), .param_wr_data(wr_data), .accel_time_one_param(accel_one));
  dsr_link_sva u_dsr_link_sva (.clk_sys(clk_sys), .rst(rst), .req_valid(link.req_valid),
    .req_func(link.req_func), .req_addr(link.req_addr), .req_wdata(link.req_wdata),
    .rsp_valid(link.rsp_valid), .rsp_exc(link.rsp_exc), .rsp_data(link.rsp_data));

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task conclude();
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input dsr_word_t got, input dsr_word_t exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // The trailing delay lets outputs launched by the final edge settle first.
  task sw_write(input logic [3:0] a, input dsr_word_t d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
    #1;
  endtask

  task sw_read(input logic [3:0] a, output dsr_word_t d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask

  // Busy is polled a bounded number of times so a stuck link cannot hang the run.
  task expect_op(input logic wr, input dsr_word_t a, input dsr_word_t d,
                 input dsr_word_t exp, input logic exc);
    int n;
    n = 0;
    sw_write(`DSR_H_ADDR, a);
    sw_write(`DSR_H_WDATA, d);
    sw_write(`DSR_H_CTRL, wr ? 16'h0003 : 16'h0001);
    stat = 16'h0001;
    while (stat[0] !== 1'b0 && n < 8) begin
      sw_read(`DSR_H_STAT, stat);
      n++;
    end
    sw_read(`DSR_H_RDATA, rd);
    chk(stat, {14'h0000, exc, 1'b0});
    if (!exc)
      chk(rd, exp);
  endtask

  always @(posedge clk_sys) begin
    if (wr_pulse === 1'b1)
      pulses <= pulses + 16'h0001;
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      conclude();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    sw_read(`DSR_H_RDATA, rd);
    chk(rd, `DSR_H_RESET_WORD);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_sys);
      st <= 12'h001 << i;
      flt <= (i == 7) ? 24'h00_0001 : 24'h00_0000;
      expect_op(1'b0, `DSR_ADDR_LOGIC_STATUS, 16'h0000, 16'h0001 << i, 1'b0);
    end
    @(posedge clk_sys);
    st <= 12'h000;
    flt <= 24'h00_0000;
    din <= 4'hb;
    expect_op(1'b0, `DSR_ADDR_LOGIC_STATUS, 16'h0000, 16'hb000, 1'b0);
    @(posedge clk_sys);
    rev <= 8'h01;
    expect_op(1'b0, `DSR_ADDR_LOGIC_STATUS, 16'h0000, 16'h3000, 1'b0);
    expect_op(1'b0, `DSR_ADDR_FAULT_CODE, 16'h0000, 16'h0000, 1'b0);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_sys);
      flt <= 24'h00_0001 << i;
      expect_op(1'b0, `DSR_ADDR_FAULT_CODE, 16'h0000, fcode[i], 1'b0);
    end
    @(posedge clk_sys);
    flt <= '1;
    expect_op(1'b0, `DSR_ADDR_FAULT_CODE, 16'h0000, 16'h0002, 1'b0);
    @(posedge clk_sys);
    flt <= '0;
    freq <= 16'h012c;
    expect_op(1'b0, `DSR_ADDR_FREQ_FEEDBACK, 16'h0000, 16'h012c, 1'b0);
    expect_op(1'b0, `DSR_ADDR_OUT_FREQ_PARAM, 16'h0000, 16'h012c, 1'b0);
    expect_op(1'b1, `DSR_ADDR_ACCEL_ONE_PARAM, 16'h01f4, 16'h01f4, 1'b0);
    chk(accel_one, 16'h01f4);
    chk(wr_num, 16'h0027);
    chk(pulses, 16'h0001);
    chk(wr_data, 16'h01f4);
    sw_read(`DSR_H_CTRL, rd);
    chk(rd, 16'h0002);
    expect_op(1'b0, `DSR_ADDR_ACCEL_ONE_PARAM, 16'h0000, 16'h01f4, 1'b0);
    @(posedge clk_sys);
    st <= 12'h800;
    expect_op(1'b1, `DSR_ADDR_ACCEL_ONE_PARAM, 16'h0064, 16'h0000, 1'b1);
    chk(accel_one, 16'h01f4);
    chk(pulses, 16'h0001);
    @(posedge clk_sys);
    st <= 12'h000;
    expect_op(1'b1, `DSR_ADDR_OUT_FREQ_PARAM, 16'h0064, 16'h0000, 1'b1);
    // Sticky status, mask and write-one-to-clear of the master end.
    sw_write(`DSR_H_IRQ_STAT, 16'h0003);
    sw_write(`DSR_H_IRQ_MASK, 16'h0002);
    expect_op(1'b0, `DSR_ADDR_FAULT_CODE, 16'h0000, 16'h0000, 1'b0);
    chk({15'h0000, irq}, 16'h0000);
    expect_op(1'b0, 16'h2102, 16'h0000, 16'h0000, 1'b1);
    chk({15'h0000, irq}, 16'h0001);
    sw_read(`DSR_H_IRQ_STAT, rd);
    chk(rd, 16'h0003);
    sw_write(`DSR_H_IRQ_STAT, 16'h0002);
    chk({15'h0000, irq}, 16'h0000);
    sw_read(`DSR_H_IRQ_STAT, rd);
    chk(rd, 16'h0001);
    conclude();
  end
endmodule
